// ### inc/sdfe_pkg.sv
// Constants, register map and types of the memory card bus front end
//------------------------------------------------------------------------------
// Summary of operation
// [RULE_01] Protocol chosen at reset command, then kept
// [RULE_02] Identification mode until address publish command
// [RULE_03] Data transfer mode once address first published
// [RULE_04] Host identifies all cards before data transfer
// [RULE_05] Card transmits only in reply to host
// [RULE_06] One bit per host clock per line
// [RULE_07] Host clock zero to 25 or 50 MHz
// [RULE_08] Data readable regardless of speed mode used
// [RULE_09] Command line open-drain init, push-pull later
// [RULE_10] Commands in, responses out on command line
// [RULE_11] Data lines push-pull, one driver only
// [RULE_12] Data lines 1-3 inputs until bus width
// [RULE_13] Card detect pull-up on, cleared by command
// [RULE_14] Pin 1: data 3 in SD, chip select SPI
// [RULE_15] Chip select is active low
// [RULE_16] SPI: serial in on MOSI, out MISO
// [RULE_17] Line activity resynchronised into internal clock
// [RULE_18] Card proposes 16-bit relative address, host approves
// [RULE_19] 128-bit card specific data register kept
// [RULE_20] Sample on host rising edge, change after
//------------------------------------------------------------------------------
`default_nettype none

package sdfe_pkg;

  //----------------------------------------------------------------------------
  // Register byte offsets
  //----------------------------------------------------------------------------
  localparam logic [7:0] OFS_IDENT    = 8'h00;  // Four words, low word first
  localparam logic [7:0] OFS_RELADDR  = 8'h10;
  localparam logic [7:0] OFS_CARDDATA = 8'h14;  // Four words, low word first
  localparam logic [7:0] OFS_OPCOND   = 8'h24;
  localparam logic [7:0] OFS_CSW  = 8'h28;
  localparam logic [7:0] OFS_CTRL = 8'h2C;
  localparam logic [7:0] OFS_DTX  = 8'h30;
  localparam logic [7:0] OFS_DRX  = 8'h34;

  // Control register fields
  localparam int CTRL_DGO_BIT = 16;  // Write 1 to start a data word send

  // Card state word fields
  localparam int CSW_XFER   = 0;
  localparam int CSW_SPI    = 1;
  localparam int CSW_WIDE   = 2;
  localparam int CSW_PULLUP = 3;
  localparam int CSW_DBUSY  = 4;
  localparam int CSW_SEL    = 5;
  localparam int CSW_APP    = 6;

  // Reset values
  localparam logic [15:0] RST_RELADDR   = 16'h0000;
  localparam logic [15:0] RST_ADDR_PROP = 16'h0001;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;

  //----------------------------------------------------------------------------
  // Command set and frame layout
  //----------------------------------------------------------------------------
  localparam logic [5:0]  CMD_RESET    = 6'h00;
  localparam logic [5:0]  CMD_PUB_ADDR = 6'h03;
  localparam logic [5:0]  CMD_APP      = 6'h37;
  localparam logic [5:0]  ACMD_WIDTH   = 6'h06;
  localparam logic [5:0]  ACMD_CDPU    = 6'h2A;
  localparam logic [1:0]  WIDTH_1BIT   = 2'h0;
  localparam logic [1:0]  WIDTH_4BIT   = 2'h2;
  localparam logic [5:0]  FRAME_BITS   = 6'h30;  // 48-bit command and reply
  localparam logic [5:0]  SPI_RESP_BITS = 6'h08;
  localparam logic [5:0]  WORD_BITS_1  = 6'h20;  // Chunks per word, 1 lane
  localparam logic [5:0]  WORD_BITS_4  = 6'h08;  // Chunks per word, 4 lanes
  localparam logic [15:0] R6_STATUS    = 16'h0000;
  localparam logic [6:0]  R6_CRC_FILL  = 7'h00;

  //----------------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------------
  localparam int SYS_CLK_HZ      = 125_000_000;
  localparam int HOST_CLK_DS_HZ  = 25_000_000;
  localparam int HOST_CLK_HS_HZ  = 50_000_000;
  localparam int MIN_SAMPLES     = 2;  // Samples per host clock for edge finding

  // AXI responses
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic {
    SDFE_ID_MODE,
    SDFE_XFER_MODE
  } sdfe_mode_t;

endpackage

`default_nettype wire

// ### rtl/sdfe_card_front_end.sv
// Card-side bus front end: protocol select, operating modes, pins, registers
`default_nettype none

module sdfe_card_front_end #(
  parameter logic [127:0] IDENT_VALUE    = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF, // Arbitrary
  parameter logic [127:0] CARDDATA_VALUE = 128'h0000_0000_0000_0000_0000_0000_0000_0000,
  parameter logic [31:0]  OPCOND_VALUE   = 32'h0000_0000,
  parameter int           SYS_HZ     = sdfe_pkg::SYS_CLK_HZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        card_clk_i,
  input  wire logic        cmd_i,
  output var  logic        cmd_o,
  output var  logic        cmd_oe,
  input  wire logic [3:0]  dat_i,
  output var  logic [3:0]  dat_o,
  output var  logic [3:0]  dat_oe,
  output var  logic        detect_pullup_en
);
  import sdfe_pkg::*;

  //----------------------------------------------------------------------------
  // Elaboration check
  //----------------------------------------------------------------------------
  // Edge finding needs at least two samples per fastest host clock
  if (SYS_HZ < MIN_SAMPLES * HOST_CLK_HS_HZ) begin : g_bad_clock // [RULE_07]
    $error("system clock too slow to sample the host clock");
  end

  //----------------------------------------------------------------------------
  // Pin synchroniser and host clock edge
  //----------------------------------------------------------------------------
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic       clk_prev_q;
  logic       rise;
  logic       host_cmd;
  logic [3:0] host_dat;
  logic       cs_n;

  // Two stages per pin; only the second stage is looked at
  always_ff @(posedge aclk) begin // [RULE_17]
    if (!aresetn) begin
      sync1_q    <= 6'h3F;
      sync2_q    <= 6'h3F;
      clk_prev_q <= 1'b1;
    end else begin
      sync1_q    <= {card_clk_i, cmd_i, dat_i};
      sync2_q    <= sync1_q;
      clk_prev_q <= sync2_q[5];
    end
  end

  assign rise     = sync2_q[5] & ~clk_prev_q; // [RULE_20]
  assign host_cmd = sync2_q[4];
  assign host_dat = sync2_q[3:0];
  assign cs_n     = host_dat[3];  // Pin 1 is chip select in SPI mode [RULE_14] [RULE_15]

  //----------------------------------------------------------------------------
  // Mode state
  //----------------------------------------------------------------------------
  sdfe_mode_t  mode_q;
  logic        spi_q;
  logic        sel_q;
  logic        app_q;
  logic        wide_q;
  logic        pull_q;
  logic [15:0] reladdr_q;
  logic [15:0] addr_prop_q;

  //----------------------------------------------------------------------------
  // Command receiver
  //----------------------------------------------------------------------------
  logic        rx_act_q;
  logic [5:0]  rx_cnt_q;
  logic [46:0] rx_sh_q;
  logic        cmd_done_q;
  logic        tx_busy;
  logic        listen;
  logic        cmd_ok;
  logic [5:0]  cmd_idx;
  logic [31:0] cmd_arg;

  // In SPI mode only a selected card listens
  assign listen = !spi_q || !cs_n;

  // Start bit low, then 47 bits MSB first; nothing is heard while replying
  always_ff @(posedge aclk) begin // [RULE_06] [RULE_10]
    if (!aresetn) begin
      rx_act_q   <= 1'b0;
      rx_cnt_q   <= 6'h00;
      rx_sh_q    <= '0;
      cmd_done_q <= 1'b0;
    end else begin
      cmd_done_q <= 1'b0;
      if (spi_q && cs_n) begin
        rx_act_q <= 1'b0;  // Deselect aborts a half-heard frame [RULE_15]
      end else if (rise && !tx_busy && listen) begin
        if (!rx_act_q) begin
          if (!host_cmd) begin
            rx_act_q <= 1'b1;
            rx_cnt_q <= 6'h01;
          end
        end else begin
          rx_sh_q <= {rx_sh_q[45:0], host_cmd};
          if (rx_cnt_q == FRAME_BITS - 6'h01) begin
            rx_act_q   <= 1'b0;
            cmd_done_q <= 1'b1;
          end else begin
            rx_cnt_q <= rx_cnt_q + 6'h01;
          end
        end
      end
    end
  end

  // Frame must carry the host direction bit and the end bit
  assign cmd_ok  = cmd_done_q & rx_sh_q[46] & rx_sh_q[0];
  assign cmd_idx = rx_sh_q[45:40];
  assign cmd_arg = rx_sh_q[39:8];

  // Command match, plain or application-prefixed
  function automatic logic sdfe_hit(input logic [5:0] idx, input logic app,
                                    input logic [5:0] want, input logic want_app);
    return (idx == want) && (app == want_app);
  endfunction

  logic reset_hit;
  logic pub_hit;
  logic width_hit;
  logic cdpu_hit;
  logic spi_next;

  assign reset_hit = cmd_ok & sdfe_hit(cmd_idx, app_q, CMD_RESET, 1'b0);
  assign pub_hit   = cmd_ok & sdfe_hit(cmd_idx, app_q, CMD_PUB_ADDR, 1'b0) & !spi_q;
  assign width_hit = cmd_ok & sdfe_hit(cmd_idx, app_q, ACMD_WIDTH, 1'b1);
  assign cdpu_hit  = cmd_ok & sdfe_hit(cmd_idx, app_q, ACMD_CDPU, 1'b1);
  // Protocol that the reply to this command must use
  assign spi_next  = sel_q ? spi_q : !cs_n;

  //----------------------------------------------------------------------------
  // Protocol and operating mode
  //----------------------------------------------------------------------------
  // The first reset command fixes the protocol until aresetn is next asserted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q <= 1'b0;
      spi_q <= 1'b0;
    end else if (reset_hit && !sel_q) begin
      sel_q <= 1'b1; // [RULE_01]
      spi_q <= !cs_n; // [RULE_01] [RULE_14]
    end
  end

  // Identification until the address is published, then data transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= SDFE_ID_MODE;
      reladdr_q <= RST_RELADDR;
    end else if (reset_hit) begin
      mode_q <= SDFE_ID_MODE; // [RULE_02]
    end else if (pub_hit) begin
      mode_q <= SDFE_XFER_MODE; // [RULE_03]
      reladdr_q <= addr_prop_q; // [RULE_18]
    end
  end

  // Application prefix lasts for exactly one following command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      app_q <= 1'b0;
    end else if (cmd_ok) begin
      app_q <= sdfe_hit(cmd_idx, app_q, CMD_APP, 1'b0);
    end
  end

  // Bus width and card detect pull-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wide_q <= 1'b0;
      pull_q <= 1'b1; // [RULE_13]
    end else if (reset_hit) begin
      wide_q <= 1'b0; // [RULE_12]
      pull_q <= 1'b1; // [RULE_13]
    end else begin
      if (width_hit && cmd_arg[1:0] == WIDTH_4BIT) begin
        wide_q <= 1'b1; // [RULE_12]
      end else if (width_hit && cmd_arg[1:0] == WIDTH_1BIT) begin
        wide_q <= 1'b0;
      end
      if (cdpu_hit) begin
        pull_q <= cmd_arg[0]; // [RULE_13]
      end
    end
  end

  assign detect_pullup_en = pull_q; // [RULE_13]

  //----------------------------------------------------------------------------
  // Reply transmitter
  //----------------------------------------------------------------------------
  logic        tx_pend_q;
  logic        tx_act_q;
  logic [5:0]  tx_cnt_q;
  logic [47:0] tx_sh_q;
  logic        idle_bit;

  assign tx_busy  = tx_pend_q | tx_act_q;
  assign idle_bit = reset_hit || (mode_q == SDFE_ID_MODE);

  // Loaded only by a finished command; first bit goes out at the next rise
  always_ff @(posedge aclk) begin // [RULE_05]
    if (!aresetn) begin
      tx_pend_q <= 1'b0;
      tx_act_q  <= 1'b0;
      tx_cnt_q  <= 6'h00;
      tx_sh_q   <= 48'hFFFF_FFFF_FFFF;
    end else if (cmd_ok && spi_next) begin
      tx_pend_q <= 1'b1;
      tx_cnt_q  <= SPI_RESP_BITS;
      tx_sh_q   <= {1'b0, 6'h00, idle_bit, 40'hFF_FFFF_FFFF}; // [RULE_16]
    end else if (pub_hit) begin
      tx_pend_q <= 1'b1;
      tx_cnt_q  <= FRAME_BITS;
      tx_sh_q   <= {2'h0, CMD_PUB_ADDR, addr_prop_q, R6_STATUS, R6_CRC_FILL, 1'b1}; // [RULE_18]
    end else if (rise && tx_pend_q) begin
      tx_pend_q <= 1'b0;
      tx_act_q  <= 1'b1; // [RULE_20]
    end else if (rise && tx_act_q) begin
      if (tx_cnt_q == 6'h01) begin
        tx_act_q <= 1'b0;
        tx_sh_q  <= 48'hFFFF_FFFF_FFFF;
      end else begin
        tx_cnt_q <= tx_cnt_q - 6'h01;
        tx_sh_q  <= {tx_sh_q[46:0], 1'b1}; // One bit per host clock [RULE_06]
      end
    end
  end

  // Open-drain while identifying, push-pull once in data transfer
  assign cmd_o  = tx_sh_q[47]; // [RULE_10]
  assign cmd_oe = tx_act_q && !spi_q &&
                  (mode_q == SDFE_XFER_MODE || !tx_sh_q[47]); // [RULE_09]

  //----------------------------------------------------------------------------
  // Data lines
  //----------------------------------------------------------------------------
  logic [31:0] dtx_q;
  logic [31:0] dsh_q;
  logic [5:0]  dcnt_q;
  logic        ddrive_q;
  logic [3:0]  dat_o_q;
  logic [31:0] drx_q;
  logic        dgo;
  logic        dbusy;

  assign dbusy = (dcnt_q != 6'h00) || ddrive_q;

  // Word sender; timing is host-clock driven, so any speed mode reads back
  always_ff @(posedge aclk) begin // [RULE_08]
    if (!aresetn) begin
      dsh_q    <= RST_WORD;
      dcnt_q   <= 6'h00;
      ddrive_q <= 1'b0;
      dat_o_q  <= 4'hF;
    end else if (dgo && dcnt_q == 6'h00) begin
      dsh_q  <= dtx_q;
      dcnt_q <= wide_q ? WORD_BITS_4 : WORD_BITS_1;
    end else if (rise) begin
      if (dcnt_q != 6'h00) begin
        ddrive_q <= 1'b1;
        dcnt_q   <= dcnt_q - 6'h01;
        if (wide_q) begin
          dat_o_q <= dsh_q[31:28]; // [RULE_06]
          dsh_q   <= {dsh_q[27:0], 4'hF};
        end else begin
          dat_o_q <= {3'h7, dsh_q[31]}; // [RULE_06]
          dsh_q   <= {dsh_q[30:0], 1'b1};
        end
      end else begin
        ddrive_q <= 1'b0;
      end
    end
  end

  // Capture what the host drives while the card keeps off the lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drx_q <= RST_WORD;
    end else if (rise && !dbusy && !spi_q && mode_q == SDFE_XFER_MODE) begin
      drx_q <= wide_q ? {drx_q[27:0], host_dat} : {drx_q[30:0], host_dat[0]};
    end
  end

  // Push-pull; lines 1-3 stay inputs until four-lane width is set
  assign dat_oe[0]   = spi_q ? (tx_act_q && !cs_n) : ddrive_q; // [RULE_11] [RULE_16]
  assign dat_oe[3:1] = {3{ddrive_q && wide_q && !spi_q}}; // [RULE_11] [RULE_12]
  assign dat_o[0]    = spi_q ? tx_sh_q[47] : dat_o_q[0]; // [RULE_16]
  assign dat_o[3:1]  = dat_o_q[3:1];

  //----------------------------------------------------------------------------
  // AXI4-Lite slave
  //----------------------------------------------------------------------------
  logic        aw_hold_q;
  logic        w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic [31:0] rd_word;
  logic [7:0]  cdata_rel;

  // Word-aligned address inside the map
  function automatic logic sdfe_mapped(input logic [7:0] a);
    return (a <= OFS_DRX) && (a[1:0] == 2'h0);
  endfunction

  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_hold_q && w_hold_q;
  assign dgo = wr_fire && awaddr_q == OFS_CTRL && wstrb_q[2] && wdata_q[CTRL_DGO_BIT] &&
               mode_q == SDFE_XFER_MODE && !spi_q;

  // Address and data taken in either order, answered once both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= RST_WORD;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= sdfe_mapped(awaddr_q) ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Writable registers: proposed address and outgoing data word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_prop_q <= RST_ADDR_PROP;
      dtx_q      <= RST_WORD;
    end else if (wr_fire) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_q[b] && awaddr_q == OFS_DTX) begin
          dtx_q[8*b +: 8] <= wdata_q[8*b +: 8];
        end
        if (wstrb_q[b] && awaddr_q == OFS_CTRL && b < 2) begin
          addr_prop_q[8*b +: 8] <= wdata_q[8*b +: 8]; // [RULE_18]
        end
      end
    end
  end

  // Read multiplexer; identity and card data words sit low word first
  assign cdata_rel = s_axi_araddr - OFS_CARDDATA;
  always_comb begin
    rd_word = RST_WORD;
    if (s_axi_araddr < OFS_RELADDR) begin
      rd_word = IDENT_VALUE[32*int'(s_axi_araddr[3:2]) +: 32];
    end else if (s_axi_araddr >= OFS_CARDDATA && s_axi_araddr < OFS_OPCOND) begin
      rd_word = CARDDATA_VALUE[32*int'(cdata_rel[3:2]) +: 32]; // [RULE_19]
    end else begin
      case (s_axi_araddr)
        OFS_RELADDR: rd_word = {16'h0000, reladdr_q};
        OFS_OPCOND:  rd_word = OPCOND_VALUE;
        OFS_CTRL: rd_word = {16'h0000, addr_prop_q};
        OFS_DTX:  rd_word = dtx_q;
        OFS_DRX:  rd_word = drx_q;
        OFS_CSW: begin
          rd_word[CSW_XFER]   = (mode_q == SDFE_XFER_MODE);
          rd_word[CSW_SPI]    = spi_q;
          rd_word[CSW_WIDE]   = wide_q;
          rd_word[CSW_PULLUP] = pull_q;
          rd_word[CSW_DBUSY]  = dbusy;
          rd_word[CSW_SEL]    = sel_q;
          rd_word[CSW_APP]    = app_q;
        end
        default:  rd_word = RST_WORD;
      endcase
    end
  end

  // Read answered the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= RST_WORD;
      s_axi_rresp  <= AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= sdfe_mapped(s_axi_araddr) ? rd_word : RST_WORD;
      s_axi_rresp  <= sdfe_mapped(s_axi_araddr) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  property p_proto_lock;
    @(posedge aclk) disable iff (!aresetn) (sel_q && $past(sel_q)) |-> $stable(spi_q);
  endproperty
  a_proto_lock: assert property (p_proto_lock) else $error("protocol changed"); // [RULE_01]

  property p_leave_id;
    @(posedge aclk) disable iff (!aresetn)
      (mode_q == SDFE_XFER_MODE && $past(mode_q) == SDFE_ID_MODE) |-> $past(pub_hit);
  endproperty
  a_leave_id: assert property (p_leave_id) else $error("left identification early"); // [RULE_02]

  property p_enter_xfer;
    @(posedge aclk) disable iff (!aresetn) pub_hit |=> (mode_q == SDFE_XFER_MODE) && tx_pend_q;
  endproperty
  a_enter_xfer: assert property (p_enter_xfer) else $error("no data mode"); // [RULE_03]

  property p_reply_only;
    @(posedge aclk) disable iff (!aresetn) $rose(tx_pend_q) |-> $past(cmd_ok);
  endproperty
  a_reply_only: assert property (p_reply_only) else $error("unsolicited reply"); // [RULE_05]

  property p_one_bit;
    @(posedge aclk) disable iff (!aresetn)
      (rise && tx_act_q && tx_cnt_q > 6'h01 && !cmd_ok) |=>
        tx_sh_q == ($past(tx_sh_q) << 1) + 48'h1;
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("reply not one bit per clock"); // [RULE_06]

  property p_open_drain;
    @(posedge aclk) disable iff (!aresetn) (cmd_oe && mode_q == SDFE_ID_MODE) |-> !cmd_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("push-pull while identifying"); // [RULE_09]

  property p_narrow;
    @(posedge aclk) disable iff (!aresetn) !wide_q |-> dat_oe[3:1] == 3'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper data lines driven"); // [RULE_12]

  property p_cs_idle;
    @(posedge aclk) disable iff (!aresetn) (spi_q && cs_n) |-> (dat_oe == 4'h0) && !cmd_oe;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("driven while deselected"); // [RULE_15]

  property p_addr_take;
    @(posedge aclk) disable iff (!aresetn) pub_hit |=> reladdr_q == $past(addr_prop_q);
  endproperty
  a_addr_take: assert property (p_addr_take) else $error("address not latched"); // [RULE_18]

  property p_edge_change;
    @(posedge aclk) disable iff (!aresetn) $rose(tx_act_q) |-> $past(rise) && $past(tx_pend_q);
  endproperty
  a_edge_change: assert property (p_edge_change) else $error("output not after rise"); // [RULE_20]

  c_spi_sel:  cover property (@(posedge aclk) disable iff (!aresetn) $rose(sel_q) && spi_q);
  c_xfer:     cover property (@(posedge aclk) disable iff (!aresetn)
                              $rose(mode_q == SDFE_XFER_MODE));
  c_wide_out: cover property (@(posedge aclk) disable iff (!aresetn) ddrive_q && wide_q);

endmodule

`default_nettype wire

// ### testbench/sdfe_host_model.sv
// Host model: card clock, command frames, chip select and reply capture
`default_nettype none
module sdfe_host_model (
  output var  logic        card_clk,
  output var  logic        cmd_h,
  output var  logic        cs_n,
  input  wire logic        cmd_line,
  input  wire logic        miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [47:0] reply;
  // Clock stands low outside frames; 8 MHz is inside the allowed range
  initial begin
    card_clk = 1'b0;
    cmd_h = 1'b1;
    cs_n = 1'b1;
    reply = '0;
  end
  // One bit per clock, changed only while clock is low
  task automatic tick();
    #62.5 card_clk = 1'b1;
    #62.5 card_clk = 1'b0;
  endtask
  // Host starts every exchange, then releases the line to the pull-up
  task automatic send(input logic [5:0] idx, input logic [31:0] arg, input int n);
    logic [47:0] f;
    f = {2'b01, idx, arg, 8'h01};
    for (int i = 47; i >= 0; i--) begin
      cmd_h = f[i];
      tick();
    end
    cmd_h = 1'b1;
    // Reply bits are sampled mid-bit, on the falling edge
    for (int i = 0; i < n; i++) begin
      tick();
      reply = {reply[46:0], cmd_line & miso};  // Idle line reads 1
    end
    repeat (4) tick();
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Testbench: register access and host command sequences for the card front end
`default_nettype none
module tb;
  import sdfe_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready;
  logic        awready, wready, arready, cmd_o, cmd_oe, detect_pullup_en, card_clk, cmd_h, cs_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  dat_o, dat_oe;
  int          n_errors, check_count, cyc;
  // Wired lines: open-drain command with pull-up, chip select on pin 1
  wire         cmd_line = cmd_h & (cmd_oe ? cmd_o : 1'b1);
  wire  [3:0]  dat_line = (dat_oe & dat_o) | (~dat_oe & {cs_n, 3'h7});
  sdfe_card_front_end dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .card_clk_i(card_clk), .cmd_i(cmd_line), .cmd_o(cmd_o), .cmd_oe(cmd_oe),
    .dat_i(dat_line), .dat_o(dat_o), .dat_oe(dat_oe), .detect_pullup_en(detect_pullup_en));
  sdfe_host_model host (.card_clk(card_clk), .cmd_h(cmd_h), .cs_n(cs_n), .cmd_line(cmd_line),
    .miso(dat_line[0]));
  always #4 aclk = ~aclk;
  // Cut a hang short well beyond the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Handshakes are judged at mid-cycle, which equals the value at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        chk("bresp", er, r);
        return;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [33:0] v;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      v = {rresp, rdata};
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        chk($sformatf("reg %0h", a), {er, e}, v);
        return;
      end
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence: reset state, identification, application commands
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, n_errors, check_count, cyc} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CSW, 32'h8, AXI_OKAY);
    rd(OFS_RELADDR, 32'h0, AXI_OKAY);
    rd(8'h38, 32'h0, AXI_SLVERR);
    chk("dat_oe", 4'h0, dat_oe);
    $display("test reset done");
    wr(OFS_CTRL, 32'h1234, AXI_OKAY);
    wr(OFS_RELADDR, 32'h5555, AXI_OKAY);
    host.send(CMD_RESET, 32'h0, 0);
    rd(OFS_CSW, 32'h28, AXI_OKAY);
    host.send(CMD_PUB_ADDR, 32'h0, 48);
    chk("reply", {8'h03, 16'h1234, 16'h0, 8'h01}, host.reply);
    rd(OFS_CSW, 32'h29, AXI_OKAY);
    rd(OFS_RELADDR, 32'h1234, AXI_OKAY);
    $display("test identification done");
    host.send(CMD_APP, 32'h0, 0);
    host.send(ACMD_WIDTH, 32'h2, 0);
    host.send(CMD_APP, 32'h0, 0);
    host.send(ACMD_CDPU, 32'h0, 0);
    rd(OFS_CSW, 32'h25, AXI_OKAY);
    chk("pullup", 1'b0, detect_pullup_en);
    $display("test app commands done");
    // Mid-run reset, then select with chip select low to pick the serial protocol
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    host.cs_n = 1'b0;
    host.send(CMD_RESET, 32'h0, 8);
    chk("spi reply", 8'h01, host.reply[7:0]);
    rd(OFS_CSW, 32'h2A, AXI_OKAY);
    $display("test spi select done");
    end_of_test();
  end
endmodule
`default_nettype wire
